//--- rtl/nvmld_pkg.sv
/*
 * Constants, state enumeration and layout for the configuration word loader.
 * Assumes a 100 MHz core clock and a word-addressed serial memory reader.
 */
package nvmld_pkg;

    // ------------------------------------------------------------
    // Memory word addresses and per-port offsets
    // ------------------------------------------------------------
    localparam logic [8:0] ADDR_SIZING = 9'h012;
    localparam logic [8:0] ADDR_ICW1 = 9'h00a;
    localparam logic [8:0] ADDR_SSID = 9'h00b;
    localparam logic [8:0] ADDR_SSVID = 9'h00c;
    localparam logic [8:0] ADDR_VID = 9'h00e;
    localparam logic [8:0] ADDR_ICW2 = 9'h00f;
    localparam logic [8:0] ADDR_DUMMY = 9'h01d;
    localparam logic [8:0] OFS_DEVID = 9'h00d;
    localparam logic [8:0] OFS_ICW4 = 9'h013;
    localparam logic [8:0] OFS_MSIX = 9'h016;
    localparam logic [3:0][8:0] PORT_BASE = {9'h100, 9'h0c0, 9'h080, 9'h000};

    // ------------------------------------------------------------
    // Sizing word signature and control word layout
    // ------------------------------------------------------------
    localparam int SIG_HI = 15;
    localparam int SIG_LO = 14;
    localparam logic [1:0] SIG_VALID = 2'h1;
    localparam logic [15:0] ICW1_RST = 16'h232b;
    localparam logic [15:0] ICW2_RST = 16'h70c2;
    localparam logic [15:0] ID_ALL_ONES = 16'hffff;
    localparam logic [15:0] SSID_RST = 16'h0000;
    localparam int I1_LTR = 13;
    localparam int I1_FORCE_SPEED_DEFAULT = 11;
    localparam int I1_DUPLEX = 10;
    localparam int I1_PINHOLD = 6;
    localparam int I1_DEADLOCK = 5;
    localparam int I1_PM = 3;
    localparam int I1_LD_SUBSYS = 1;
    localparam int I1_LD_IDS = 0;
    localparam int I2_WAKE = 15;
    localparam int I2_PDET = 14;
    localparam int I2_PAUSE_HI = 13;
    localparam int I2_PAUSE_LO = 12;
    localparam int I2_ANE = 11;
    localparam int I2_FLASH_HI = 10;
    localparam int I2_FLASH_LO = 8;
    localparam int I2_MACCG = 7;
    localparam int I2_PHYPD = 6;
    localparam int I2_WINSIZE = 5;
    localparam int I2_PLLSD = 4;
    localparam int I2_DYNCG = 3;
    localparam int I2_SERDES = 2;
    localparam int I2_DMACG = 1;

    // ------------------------------------------------------------
    // APB register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ICW1 = 8'h08;
    localparam logic [7:0] REG_ICW2 = 8'h0c;
    localparam logic [7:0] REG_SUBSYS = 8'h10;
    localparam logic [7:0] REG_IDS = 8'h14;

    // ------------------------------------------------------------
    // Access grant deadlock time
    // ------------------------------------------------------------
    localparam int unsigned DEADLOCK_MS = 2000;
    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned DEADLOCK_CYC = DEADLOCK_MS * CLK_KHZ;

    typedef enum logic [3:0] {
        ST_SIG, ST_ICW1, ST_ICW2, ST_SSID, ST_SSVID, ST_VID, ST_DUMMY,
        ST_MAC0, ST_MAC1, ST_MAC2, ST_DEVID, ST_ICW4, ST_MSIX, ST_DONE
    } nvmld_state_t;

endpackage : nvmld_pkg

//--- rtl/nvmld_wd_if.sv
/*
 * Carrier between the loader and its access grant watchdog.
 * Assumes both ends share the core clock.
 */
interface nvmld_wd_if;
    logic en;
    logic grant;
    logic toggle;
    logic revoke;
    modport ldr (output en, output grant, output toggle, input revoke);
    modport wd (input en, input grant, input toggle, output revoke);
endinterface : nvmld_wd_if

//--- rtl/nvmld_watchdog.sv
/*
 * Access grant watchdog: revokes a grant left idle too long.
 * Assumes grant and toggle are synchronous to the core clock.
 */
module nvmld_watchdog
    import nvmld_pkg::*;
#(
    parameter int unsigned LIMIT = DEADLOCK_CYC
) (
    input wire logic i_sys_clk, // Core clock
    input wire logic i_rst_n,   // Async reset, active low
    nvmld_wd_if.wd wd           // Loader side
);

    typedef struct packed {
        logic [31:0] cnt;
        logic revoke;
    } nvmld_wd_st_t;

    nvmld_wd_st_t r, n;

    // ------------------------------------------------------------
    // Idle counter
    // ------------------------------------------------------------
    // Count idle cycles while enabled and granted
    always_comb begin
        n = r;
        if (!wd.grant || wd.toggle || !wd.en) begin
            n.cnt = '0;
            n.revoke = 1'b0;
        end else if (r.cnt >= LIMIT) begin
            n.revoke = 1'b1; // see RL10
        end else begin
            n.cnt = r.cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign wd.revoke = r.revoke;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    a_revoke_after_idle: assert property (wd.revoke |-> $past(r.cnt) >= LIMIT) // see RL10
        else $error("revoke without full idle time");

endmodule : nvmld_watchdog

//--- rtl/nvmld_loader.sv
/*
 * Configuration word loader: after reset reads the sizing word and, if its signature is valid, the two
 * control words, the ID words enabled by control word one and each port's section, and holds them.
 * Assumes a word reader that answers each held request with one ack pulse.
 */
// Summary of operation
// RL1: Load words only with valid sizing signature
// RL2: Signature 01b else no reads, defaults
// RL3: Port bases 0x0, 0x80, 0xC0, 0x100
// RL4: Words absolute, offsets relative to base
// RL5: Three words form port station address
// RL6: Device ID, control four, vector offsets
// RL7: Control one bit 13 reports latency
// RL8: Bits 11, 10 give speed, duplex defaults
// RL9: Bit 6 holds pins in idle
// RL10: Bit 5 revokes idle grant after 2s
// RL11: Bit 3 enables full power management
// RL12: Bit 1 loads subsystem IDs
// RL13: Bit 0 loads vendor and device IDs
// RL14: All-ones vendor word keeps default
// RL15: Control two gives PCS and wake defaults
// RL16: Bits 10:8 select flash size
// RL17: Zero window and flash disables BAR
// RL18: MAC gating needs dynamic gating bit
// RL19: Bit 6 allows PHY low power
// RL20: Bit 4 allows PLL shutdown
// RL21: Bit 2 allows serializer low power
// RL22: Bit 1 disables DMA clock gating
// RL23: Finish loading before configuration accesses
module nvmld_loader
    import nvmld_pkg::*;
#(
    parameter int NUM_PORTS = 4,
    parameter logic [15:0] VID_DEFAULT = 16'h1d1d,    // Arbitrary value
    parameter logic [15:0] DEVID_DEFAULT = 16'h2e2e,  // Arbitrary value
    parameter logic [15:0] DUMMY_DEFAULT = 16'h3f3f,  // Arbitrary value
    parameter int unsigned DEADLOCK_LIMIT = DEADLOCK_CYC
) (
    input wire logic i_sys_clk,                  // Core clock
    input wire logic i_rst_n,                    // Async reset, active low
    output logic o_mem_req,                      // Word read request
    output logic [8:0] o_mem_addr,               // Word address
    input wire logic i_mem_ack,                  // Word returned
    input wire logic [15:0] i_mem_data,          // Returned word
    input wire logic i_psel,                     // APB select
    input wire logic i_penable,                  // APB enable
    input wire logic i_pwrite,                   // APB direction
    input wire logic [7:0] i_paddr,              // APB byte address
    input wire logic [31:0] i_pwdata,            // APB write data
    output logic [31:0] o_prdata,                // APB read data
    output logic o_pready,                       // APB ready
    output logic o_pslverr,                      // APB error
    input wire logic i_acc_grant,                // Requester holds grant
    input wire logic i_acc_toggle,               // Requester interface activity
    output logic o_grant_revoke,                 // Grant withdrawn
    output logic o_cfg_ready,                    // Loading finished
    output logic o_sig_valid,                    // Signature was valid
    output logic [NUM_PORTS*48-1:0] o_receive_address_zero, // Station addresses
    output logic [NUM_PORTS*16-1:0] o_device_id, // Per-function device ID
    output logic [NUM_PORTS*16-1:0] o_icw4,      // Per-port control word four
    output logic [NUM_PORTS*16-1:0] o_msix_cfg,  // Per-port vector config
    output logic [15:0] o_vendor_id,             // PCIe vendor ID
    output logic [15:0] o_dummy_device_id,       // Dummy function device ID
    output logic [15:0] o_subsys_id,             // PCIe subsystem ID
    output logic [15:0] o_subsys_vendor_id,      // PCIe subsystem vendor ID
    output logic o_latency_report_enable,        // Latency support advertised
    output logic o_force_speed_default,          // Force speed default
    output logic o_full_duplex_default,          // Duplex default
    output logic o_pin_hold_in_idle_enable,      // Pins hold in idle
    output logic o_pm_full_support,              // Full power management
    output logic o_wake_power_event_enable,      // Wake event default
    output logic o_parallel_detect_enable,       // PCS parallel detect
    output logic [1:0] o_advertised_pause_field, // Pause advertisement
    output logic o_autoneg_enable_default,       // Autoneg default
    output logic [2:0] o_flash_size_sel,         // Flash size exponent
    output logic o_register_window_size,         // Register window size
    output logic o_flash_bar_enable,             // Flash BAR present
    output logic o_mac_cg_status,                // Status bit 31 mirror
    output logic o_mac_cg_active,                // MAC clock gating in effect
    output logic o_phy_pd_enable,                // Extended control bit 20
    output logic o_pll_shutdown_enable,          // PHY PLL shutdown allowed
    output logic o_serdes_lp_enable,             // Serializer low power
    output logic o_dma_cg_disable                // DMA clock gating off
);

    localparam logic FLASH_BAR_RST =
        ICW2_RST[I2_WINSIZE] | (|ICW2_RST[I2_FLASH_HI:I2_FLASH_LO]);
    localparam logic MACCG_RST = ICW2_RST[I2_MACCG] & ICW2_RST[I2_DYNCG];

    typedef struct packed {
        nvmld_state_t state;
        logic [1:0] port;
        logic req;
        logic [8:0] addr;
        logic sig_ok;
        logic [15:0] icw1;
        logic [15:0] icw2;
        logic flash_bar;
        logic maccg;
        logic [15:0] ssid;
        logic [15:0] ssvid;
        logic [15:0] vid;
        logic [15:0] dummy;
        logic [NUM_PORTS-1:0][47:0] mac;
        logic [NUM_PORTS-1:0][15:0] devid;
        logic [NUM_PORTS-1:0][15:0] icw4;
        logic [NUM_PORTS-1:0][15:0] msix;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } nvmld_st_t;

    nvmld_st_t r, n;
    nvmld_wd_if wd_if ();

    // ------------------------------------------------------------
    // Word address of each fetch step
    // ------------------------------------------------------------
    // Common words absolute, port words relative to base
    function automatic logic [8:0] step_addr(input nvmld_state_t s, input logic [1:0] p);
        logic [8:0] base;
        base = PORT_BASE[p]; // see RL3
        case (s)
            ST_SIG: step_addr = ADDR_SIZING;
            ST_ICW1: step_addr = ADDR_ICW1;
            ST_ICW2: step_addr = ADDR_ICW2;
            ST_SSID: step_addr = ADDR_SSID;
            ST_SSVID: step_addr = ADDR_SSVID;
            ST_VID: step_addr = ADDR_VID;
            ST_DUMMY: step_addr = ADDR_DUMMY;
            ST_MAC0: step_addr = base; // see RL4
            ST_MAC1: step_addr = base + 9'h001;
            ST_MAC2: step_addr = base + 9'h002;
            ST_DEVID: step_addr = base + OFS_DEVID; // see RL6
            ST_ICW4: step_addr = base + OFS_ICW4;
            ST_MSIX: step_addr = base + OFS_MSIX;
            default: step_addr = 9'h000;
        endcase
    endfunction : step_addr

    // Reset image: defaults, first fetch pending
    function automatic nvmld_st_t boot_value();
        nvmld_st_t b;
        b = '0;
        b.state = ST_SIG;
        b.req = 1'b1;
        b.addr = ADDR_SIZING;
        b.icw1 = ICW1_RST;
        b.icw2 = ICW2_RST;
        b.flash_bar = FLASH_BAR_RST;
        b.maccg = MACCG_RST;
        b.ssid = SSID_RST;
        b.ssvid = VID_DEFAULT;
        b.vid = VID_DEFAULT;
        b.dummy = DUMMY_DEFAULT;
        for (int i = 0; i < NUM_PORTS; i++) begin
            b.devid[i] = DEVID_DEFAULT;
        end
        return b;
    endfunction : boot_value

    // ------------------------------------------------------------
    // Load sequencer and register bus
    // ------------------------------------------------------------
    always_comb begin
        logic take;
        logic setup;
        nvmld_state_t nx;
        take = r.req && i_mem_ack;
        setup = i_psel && !i_penable;
        nx = r.state;
        n = r;
        if (take) begin
            n.req = 1'b0;
            case (r.state)
                ST_SIG: begin
                    if (i_mem_data[SIG_HI:SIG_LO] == SIG_VALID) begin // see RL1
                        n.sig_ok = 1'b1;
                        nx = ST_ICW1;
                    end else begin
                        nx = ST_DONE; // see RL2
                    end
                end
                ST_ICW1: begin
                    n.icw1 = i_mem_data;
                    nx = ST_ICW2;
                end
                ST_ICW2: begin
                    n.icw2 = i_mem_data;
                    n.flash_bar = i_mem_data[I2_WINSIZE] |
                                  (|i_mem_data[I2_FLASH_HI:I2_FLASH_LO]); // see RL17
                    n.maccg = i_mem_data[I2_MACCG] & i_mem_data[I2_DYNCG]; // see RL18
                    if (r.icw1[I1_LD_SUBSYS]) begin // see RL12
                        nx = ST_SSID;
                    end else if (r.icw1[I1_LD_IDS]) begin // see RL13
                        nx = ST_VID;
                    end else begin
                        nx = ST_MAC0;
                    end
                end
                ST_SSID: begin
                    n.ssid = i_mem_data; // see RL12
                    nx = ST_SSVID;
                end
                ST_SSVID: begin
                    n.ssvid = i_mem_data;
                    nx = r.icw1[I1_LD_IDS] ? ST_VID : ST_MAC0;
                end
                ST_VID: begin
                    if (i_mem_data != ID_ALL_ONES) begin // see RL14
                        n.vid = i_mem_data; // see RL13
                    end
                    nx = ST_DUMMY;
                end
                ST_DUMMY: begin
                    n.dummy = i_mem_data;
                    nx = ST_MAC0;
                end
                ST_MAC0: begin
                    n.mac[r.port][15:0] = i_mem_data; // see RL5
                    nx = ST_MAC1;
                end
                ST_MAC1: begin
                    n.mac[r.port][31:16] = i_mem_data;
                    nx = ST_MAC2;
                end
                ST_MAC2: begin
                    n.mac[r.port][47:32] = i_mem_data;
                    nx = r.icw1[I1_LD_IDS] ? ST_DEVID : ST_ICW4;
                end
                ST_DEVID: begin
                    n.devid[r.port] = i_mem_data; // see RL6
                    nx = ST_ICW4;
                end
                ST_ICW4: begin
                    n.icw4[r.port] = i_mem_data;
                    nx = ST_MSIX;
                end
                ST_MSIX: begin
                    n.msix[r.port] = i_mem_data;
                    if (r.port == 2'(NUM_PORTS - 1)) begin
                        nx = ST_DONE;
                    end else begin
                        n.port = r.port + 2'h1;
                        nx = ST_MAC0;
                    end
                end
                default: nx = ST_DONE;
            endcase
            n.state = nx;
            if (nx != ST_DONE) begin
                n.req = 1'b1;
                n.addr = step_addr(nx, n.port);
            end
        end
        // APB: decode in setup, answer in access phase
        n.pready = setup;
        n.pslverr = 1'b0;
        if (setup) begin
            n.prdata = '0;
            if (i_paddr == REG_CTRL) begin
                n.prdata = '0;
            end else if (i_paddr == REG_STATUS) begin
                n.prdata = {29'h0, r.state != ST_DONE, r.sig_ok, r.state == ST_DONE};
            end else if (i_paddr == REG_ICW1) begin
                n.prdata = {16'h0, r.icw1};
            end else if (i_paddr == REG_ICW2) begin
                n.prdata = {16'h0, r.icw2};
            end else if (i_paddr == REG_SUBSYS) begin
                n.prdata = {r.ssvid, r.ssid};
            end else if (i_paddr == REG_IDS) begin
                n.prdata = {r.dummy, r.vid};
            end else begin
                n.pslverr = 1'b1;
            end
        end
        // Reload request only accepted once idle
        if (r.pready && i_psel && i_penable && i_pwrite && i_paddr == REG_CTRL &&
            i_pwdata[0] && r.state == ST_DONE) begin
            n = boot_value();
        end
    end

    // State register
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r <= boot_value();
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Watchdog hookup
    // ------------------------------------------------------------
    assign wd_if.en = r.icw1[I1_DEADLOCK]; // see RL10
    assign wd_if.grant = i_acc_grant;
    assign wd_if.toggle = i_acc_toggle;

    nvmld_watchdog #(.LIMIT(DEADLOCK_LIMIT)) u_wd (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .wd(wd_if.wd)
    );

    // ------------------------------------------------------------
    // Outputs from state
    // ------------------------------------------------------------
    assign o_mem_req = r.req;
    assign o_mem_addr = r.addr;
    assign o_prdata = r.prdata;
    assign o_pready = r.pready;
    assign o_pslverr = r.pslverr;
    assign o_grant_revoke = wd_if.revoke;
    assign o_cfg_ready = (r.state == ST_DONE) && !r.req; // see RL23
    assign o_sig_valid = r.sig_ok;
    assign o_receive_address_zero = r.mac;
    assign o_device_id = r.devid;
    assign o_icw4 = r.icw4;
    assign o_msix_cfg = r.msix;
    assign o_vendor_id = r.vid;
    assign o_dummy_device_id = r.dummy;
    assign o_subsys_id = r.ssid;
    assign o_subsys_vendor_id = r.ssvid;
    // Control word one fields
    assign o_latency_report_enable = r.icw1[I1_LTR]; // see RL7
    assign o_force_speed_default = r.icw1[I1_FORCE_SPEED_DEFAULT]; // see RL8
    assign o_full_duplex_default = r.icw1[I1_DUPLEX]; // see RL8
    assign o_pin_hold_in_idle_enable = r.icw1[I1_PINHOLD]; // see RL9
    assign o_pm_full_support = r.icw1[I1_PM]; // see RL11
    // Control word two fields
    assign o_wake_power_event_enable = r.icw2[I2_WAKE]; // see RL15
    assign o_parallel_detect_enable = r.icw2[I2_PDET]; // see RL15
    assign o_advertised_pause_field = r.icw2[I2_PAUSE_HI:I2_PAUSE_LO]; // see RL15
    assign o_autoneg_enable_default = r.icw2[I2_ANE]; // see RL15
    assign o_flash_size_sel = r.icw2[I2_FLASH_HI:I2_FLASH_LO]; // see RL16
    assign o_register_window_size = r.icw2[I2_WINSIZE];
    assign o_flash_bar_enable = r.flash_bar;
    assign o_mac_cg_status = r.icw2[I2_MACCG]; // see RL18
    assign o_mac_cg_active = r.maccg;
    assign o_phy_pd_enable = r.icw2[I2_PHYPD]; // see RL19
    assign o_pll_shutdown_enable = r.icw2[I2_PLLSD]; // see RL20
    assign o_serdes_lp_enable = r.icw2[I2_SERDES]; // see RL21
    assign o_dma_cg_disable = r.icw2[I2_DMACG]; // see RL22

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_bad_sig;
        r.req && i_mem_ack && r.state == ST_SIG && i_mem_data[SIG_HI:SIG_LO] != SIG_VALID;
    endsequence
    sequence s_stop;
        r.state == ST_DONE && !r.req && !r.sig_ok;
    endsequence

    a_bad_sig_stops: assert property (s_bad_sig |=> s_stop ##1 !r.req) // see RL2
        else $error("reads continued after bad signature");
    a_req_held: assert property (r.req && !i_mem_ack |=> r.req && $stable(r.addr))
        else $error("request dropped before ack");
    a_port_base: assert property (r.req && r.state == ST_MAC0 |-> r.addr == PORT_BASE[r.port])
        else $error("port section base wrong"); // see RL3
    a_devid_ofs: assert property (r.req && r.state == ST_DEVID |->
        r.addr == PORT_BASE[r.port] + OFS_DEVID) // see RL6
        else $error("device ID offset wrong");
    a_vid_allones: assert property (r.req && i_mem_ack && r.state == ST_VID &&
        i_mem_data == ID_ALL_ONES |=> r.vid == $past(r.vid)) // see RL14
        else $error("all-ones vendor word was applied");
    a_subsys_skip: assert property (r.req && i_mem_ack && r.state == ST_ICW2 &&
        !r.icw1[I1_LD_SUBSYS] |=> r.state != ST_SSID) // see RL12
        else $error("subsystem IDs read while disabled");
    a_maccg_gate: assert property (o_mac_cg_active == (r.icw2[I2_MACCG] && r.icw2[I2_DYNCG]))
        else $error("MAC gating without dynamic gating"); // see RL18
    a_flash_bar: assert property (o_flash_bar_enable ==
        (r.icw2[I2_WINSIZE] || r.icw2[I2_FLASH_HI:I2_FLASH_LO] != 3'h0)) // see RL17
        else $error("flash BAR enable mismatch");
    a_ready_done: assert property (o_cfg_ready |-> r.state == ST_DONE && !o_mem_req)
        else $error("ready while still loading"); // see RL23
    a_apb_answer: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("APB answer not in access cycle");

endmodule : nvmld_loader

//--- tb/nvmld_mem_model.sv
/* Word-addressed configuration memory model.
   Assumes each request is held until its ack. */
module nvmld_mem_model (
    input wire logic i_sys_clk, // Core clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic i_req, // Read request
    input wire logic [8:0] i_addr, // Word address
    input wire logic i_slow, // Answer three cycles late
    output logic o_ack, // Word returned
    output logic [15:0] o_data, // Returned word
    output int o_n_ack // Words handed out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:511];
    int cnt;
    // Answer held requests, scramble data between
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ack <= 1'b0;
            o_data <= 16'h0;
            cnt <= 0;
            o_n_ack <= 0;
        end else if (i_req && !o_ack && cnt >= (i_slow ? 3 : 0)) begin
            o_ack <= 1'b1;
            o_data <= mem[i_addr];
            cnt <= 0;
            o_n_ack <= o_n_ack + 1;
        end else begin
            o_ack <= 1'b0;
            o_data <= ~o_data;
            cnt <= (i_req && !o_ack) ? cnt + 1 : 0;
        end
    end
endmodule : nvmld_mem_model

//--- tb/nvm_config_word_loader_test.sv
/* Self-checking loader bench.
   Assumes package, loader and model compiled first. */
module nvm_config_word_loader_test;
    import nvmld_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0, i_slow = 1;
    logic i_acc_grant = 0, i_acc_toggle = 0, o_mem_req, i_mem_ack, o_pready, o_pslverr, er;
    logic [7:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, rd;
    logic [8:0] o_mem_addr;
    logic [15:0] i_mem_data, o_vendor_id, o_dummy_device_id, o_subsys_id, o_subsys_vendor_id;
    logic [191:0] o_receive_address_zero;
    logic [63:0] o_device_id, o_icw4, o_msix_cfg;
    logic [2:0] o_flash_size_sel;
    logic [1:0] o_advertised_pause_field;
    logic o_grant_revoke, o_cfg_ready, o_sig_valid, o_latency_report_enable, o_pm_full_support;
    logic o_force_speed_default, o_full_duplex_default, o_pin_hold_in_idle_enable;
    logic o_wake_power_event_enable, o_parallel_detect_enable, o_autoneg_enable_default;
    logic o_register_window_size, o_flash_bar_enable, o_mac_cg_status, o_mac_cg_active;
    logic o_phy_pd_enable, o_pll_shutdown_enable, o_serdes_lp_enable, o_dma_cg_disable;
    int mismatches = 0, n_tests = 0, n_ack;
    nvmld_loader #(.DEADLOCK_LIMIT(20)) DUT (.*);
    nvmld_mem_model u_mem (.i_sys_clk, .i_rst_n, .i_req(o_mem_req), .i_addr(o_mem_addr),
        .i_slow, .o_ack(i_mem_ack), .o_data(i_mem_data), .o_n_ack(n_ack));
    // --------
    // Clock and tasks
    // --------
    initial forever #5 i_sys_clk = ~i_sys_clk;
    task automatic chk(input logic [95:0] s, input logic [95:0] e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic stop_test;
        if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_sys_clk);
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do @(posedge i_sys_clk); while (o_pready !== 1'b1 && ++n < 50);
        {rd, er} = {o_prdata, o_pslverr};
        {i_psel, i_penable} <= 2'b00;
    endtask : apb
    task automatic wait_done;
        int n = 0;
        while (o_cfg_ready !== 1'b1 && n++ < 2000) @(posedge i_sys_clk);
        chk(o_cfg_ready, 1);
    endtask : wait_done
    task automatic chk_bits(input logic [15:0] c1, input logic [15:0] c2);
        chk({o_latency_report_enable, o_force_speed_default, o_full_duplex_default,
            o_pin_hold_in_idle_enable, o_pm_full_support}, {c1[13], c1[11:10], c1[6],
            c1[3]});
        chk({o_wake_power_event_enable, o_parallel_detect_enable, o_advertised_pause_field,
            o_autoneg_enable_default, o_flash_size_sel, o_register_window_size, o_mac_cg_status,
            o_mac_cg_active, o_phy_pd_enable, o_pll_shutdown_enable, o_serdes_lp_enable,
            o_dma_cg_disable, o_flash_bar_enable}, {c2[15:8], c2[5], c2[7], c2[7] & c2[3], c2[6],
            c2[4], c2[2:1], c2[5] | (|c2[10:8])});
    endtask : chk_bits
    task automatic t_load_valid;
        logic [8:0] b;
        wait_done;
        chk({o_sig_valid, n_ack}, {1'b1, 32'd31});
        chk_bits(16'h2c6b, 16'h50ac);
        chk(o_vendor_id, 16'h1d1d);
        chk({o_dummy_device_id, o_subsys_vendor_id, o_subsys_id}, {u_mem.mem[9'h1d],
            u_mem.mem[9'h0c], u_mem.mem[9'h0b]});
        for (int p = 0; p < 4; p++) begin
            b = PORT_BASE[p];
            chk(o_receive_address_zero[48*p+:48], {u_mem.mem[b+2], u_mem.mem[b+1], u_mem.mem[b]});
            chk({o_device_id[16*p+:16], o_icw4[16*p+:16], o_msix_cfg[16*p+:16]}, {u_mem.mem[b+13],
                u_mem.mem[b+19], u_mem.mem[b+22]});
        end
    endtask : t_load_valid
    task automatic t_apb_regs;
        apb(0, 8'h04, 0);
        chk(rd[2:0], 3'b011);
        apb(0, 8'h08, 0);
        chk(rd[15:0], 16'h2c6b);
        apb(0, 8'h20, 0);
        chk(er, 1);
    endtask : t_apb_regs
    task automatic t_watchdog;
        i_acc_grant <= 1'b1;
        repeat (10) @(posedge i_sys_clk);
        chk(o_grant_revoke, 0);
        repeat (20) @(posedge i_sys_clk);
        chk(o_grant_revoke, 1);
        i_acc_toggle <= 1'b1;
        repeat (3) @(posedge i_sys_clk);
        chk(o_grant_revoke, 0);
        {i_acc_toggle, i_acc_grant} <= 2'b00;
    endtask : t_watchdog
    task automatic t_bad_sig;
        int n0 = n_ack;
        u_mem.mem[9'h12] = 16'h8000;
        i_slow <= 1'b0;
        apb(1, 8'h00, 32'h1);
        repeat (2) @(posedge i_sys_clk);
        wait_done;
        chk({o_sig_valid, n_ack - n0}, {1'b0, 32'd1});
        chk_bits(16'h232b, 16'h70c2);
        chk({o_vendor_id, o_dummy_device_id, o_device_id}, {16'h1d1d, 16'h3f3f, {4{16'h2e2e}}});
    endtask : t_bad_sig
    // Image and order
    initial begin
        for (int a = 0; a < 512; a++) u_mem.mem[a] = {7'h2a, a[8:0]};
        u_mem.mem[9'h12] = 16'h4000;
        u_mem.mem[9'h0a] = 16'h2c6b;
        u_mem.mem[9'h0f] = 16'h50ac;
        u_mem.mem[9'h0e] = 16'hffff;
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_load_valid;
        t_apb_regs;
        t_watchdog;
        t_bad_sig;
        stop_test;
    end
    // Hang guard
    initial begin
        #200000;
        mismatches++;
        stop_test;
    end
endmodule : nvm_config_word_loader_test
